// File: flash_command_sequencer.sv
// flash command sequencer: wishbone slave, command decoder and timed array operations
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "flash_seq_defines.svh"
// ==========================================
module flash_command_sequencer #(
  parameter int unsigned ERASE_CYCLES = `FS_ERASE_CYCLES
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [`FS_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o
);
  import flash_seq_pkg::*;

  localparam int PROG_MAX = `FS_PROG_CYCLES;

  // ==========================================
  // bus decode
  logic                 take, reg_space, fwr, frd, rwr, unmapped;
  logic [15:0]          faddr;
  logic [7:0]           wdat;

  assign take      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign reg_space = wb_adr_i[`FS_REG_SPACE];
  assign faddr     = wb_adr_i[17:2];
  assign wdat      = wb_dat_i[7:0];
  assign fwr       = take & wb_we_i & ~reg_space & wb_sel_i[0];
  assign frd       = take & ~wb_we_i & ~reg_space;
  assign rwr       = take & wb_we_i & reg_space & wb_sel_i[0];
  assign unmapped  = wb_adr_i[17:4] != 14'h0000;

  // ==========================================
  // state
  dec_state_type dec_state;
  dec_state_type next_dec;
  op_state_type  op_state;
  logic [2:0]    en_field;
  logic [1:0]    area_field;
  logic          cmd_en;
  logic [1:0]    area_sel;
  logic [1:0]    run_mode;
  logic [7:0]    security_byte;
  logic          id_mode;
  logic          toggle_bit;
  logic [21:0]   op_timer;
  logic [14:0]   sweep_idx;
  logic [14:0]   sweep_end;
  logic          sweep_done;
  logic          erase_chip;
  logic [14:0]   prog_addr;
  logic [7:0]    prog_data;
  logic          prog_end, erase_end, busy, protect, par_lock, cmd_ok;
  logic          at_a, at_b, area_ok, enter_id, exit_id;
  logic          start_prog, start_sec, start_sector, start_chip;
  logic [12:0]   prog_age;
  logic [7:0]    array_byte;
  logic [7:0]    flash_rd;
  logic [31:0]   status_word;
  logic [7:0]    mem [0:32767];

  assign busy     = op_state != OP_IDLE;
  assign protect  = security_byte != `FS_ERASED;
  assign par_lock = protect & (run_mode == `FS_MODE_PARALL);
  // held off while running: a new sequence would race the array write
  assign cmd_ok   = fwr & cmd_en & ~busy & ~par_lock;
  assign at_a     = faddr[15] & (faddr[11:0] == `FS_ADDR_A);
  assign at_b     = faddr[15] & (faddr[11:0] == `FS_ADDR_B);
  assign area_ok  = (area_sel == `FS_AREA_DATA) | (area_sel == `FS_AREA_CODE);

  // ==========================================
  // command decoder
  always_comb begin
    next_dec     = dec_state;
    start_prog   = 1'b0;
    start_sec    = 1'b0;
    start_sector = 1'b0;
    start_chip   = 1'b0;
    enter_id     = 1'b0;
    exit_id      = 1'b0;
    if (cmd_ok) begin
      next_dec = DEC_IDLE;
      case (dec_state)
        DEC_IDLE: begin
          if (at_a && wdat == `FS_UNLOCK_1) begin
            next_dec = DEC_UNLOCK1;
          end else if (wdat == `FS_CMD_ID_OUT) begin
            exit_id = 1'b1;
          end
        end
        DEC_UNLOCK1: if (at_b && wdat == `FS_UNLOCK_2) next_dec = DEC_UNLOCK2;
        DEC_UNLOCK2: begin
          if (at_a) begin
            case (wdat)
              `FS_CMD_PROG:   next_dec = DEC_PROG;
              `FS_CMD_ERASE:  next_dec = DEC_ERASE1;
              `FS_CMD_SECURE: next_dec = DEC_SECURE;
              `FS_CMD_ID_IN:  enter_id = 1'b1;
              default:        next_dec = DEC_IDLE;
            endcase
          end
        end
        DEC_PROG:    start_prog = faddr[15] & area_ok;
        DEC_SECURE:  start_sec = (faddr == `FS_SEC_ADDR) && (wdat == `FS_SEC_DATA);
        DEC_ERASE1:  if (at_a && wdat == `FS_UNLOCK_1) next_dec = DEC_ERASE2;
        DEC_ERASE2:  if (at_b && wdat == `FS_UNLOCK_2) next_dec = DEC_ERASE3;
        DEC_ERASE3: begin
          if (at_a && wdat == `FS_CMD_CHIP) begin
            start_chip = 1'b1;
          end else if (faddr[15] && wdat == `FS_CMD_SECTOR) begin
            start_sector = run_mode != `FS_MODE_PARALL;
          end
        end
        default: next_dec = DEC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_state <= DEC_IDLE;
    end else begin
      dec_state <= next_dec;
    end
  end

  // ==========================================
  // timed operation
  assign prog_end  = op_timer == 22'(`FS_PROG_CYCLES - 1);
  // array sweep and timer run together; the later of the two ends the erase
  assign erase_end = sweep_done && (op_timer >= 22'(ERASE_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      op_state   <= OP_IDLE;
      op_timer   <= 22'h000000;
      sweep_idx  <= 15'h0000;
      sweep_end  <= 15'h0000;
      sweep_done <= 1'b0;
      erase_chip <= 1'b0;
      prog_addr  <= 15'h0000;
      prog_data  <= 8'h00;
    end else begin
      case (op_state)
        OP_IDLE: begin
          op_timer   <= 22'h000000;
          sweep_done <= 1'b0;
          prog_addr  <= faddr[14:0];
          prog_data  <= wdat;
          if (start_prog) begin
            op_state <= OP_PROG;
          end else if (start_sec) begin
            op_state <= OP_SEC;
          end else if (start_sector) begin
            op_state   <= OP_ERASE;
            erase_chip <= 1'b0;
            sweep_idx  <= {faddr[14:12], 12'h000};
            sweep_end  <= {faddr[14:12], 12'hFFF};
          end else if (start_chip) begin
            op_state   <= OP_ERASE;
            erase_chip <= 1'b1;
            sweep_idx  <= 15'h0000;
            sweep_end  <= 15'h7FFF;
          end
        end
        OP_PROG, OP_SEC: begin
          op_timer <= op_timer + 22'h000001;
          if (prog_end) op_state <= OP_IDLE;
        end
        OP_ERASE: begin
          if (!erase_end) op_timer <= op_timer + 22'h000001;
          if (!sweep_done) begin
            sweep_idx  <= sweep_idx + 15'h0001;
            sweep_done <= sweep_idx == sweep_end;
          end
          if (erase_end) op_state <= OP_IDLE;
        end
        default: op_state <= OP_IDLE;
      endcase
    end
  end

  // data view and code view share these cells, so one array serves both
  always_ff @(posedge sys_clk) begin
    if (op_state == OP_PROG && prog_end) begin
      mem[prog_addr] <= prog_data;
    end else if (op_state == OP_ERASE && !sweep_done) begin
      mem[sweep_idx] <= `FS_ERASED;
    end
  end

  // protection survives everything but a chip erase or a reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      security_byte <= `FS_ERASED;
    end else if (op_state == OP_SEC && prog_end) begin
      security_byte <= prog_data;
    end else if (op_state == OP_ERASE && erase_end && erase_chip) begin
      security_byte <= `FS_ERASED;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      id_mode <= 1'b0;
    end else if (enter_id) begin
      id_mode <= 1'b1;
    end else if (exit_id) begin
      id_mode <= 1'b0;
    end
  end

  // toggle is frozen while commands are disabled
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_bit <= 1'b1;
    end else if (start_prog || start_sec || start_sector || start_chip) begin
      toggle_bit <= 1'b1;
    end else if (frd && busy && cmd_en) begin
      toggle_bit <= ~toggle_bit;
    end
  end

  // ==========================================
  // read path
  assign array_byte = faddr[15] ? mem[faddr[14:0]] : `FS_ERASED;

  always_comb begin
    flash_rd = array_byte;
    if (par_lock) begin
      flash_rd = 8'h00;
    end else if (busy) begin
      flash_rd = array_byte;
      flash_rd[`FS_TOGGLE_BIT] = toggle_bit;
    end else if (id_mode) begin
      if (faddr == `FS_ID_MAKER) begin
        flash_rd = `FS_MAKER_CODE;
      end else if (faddr == `FS_ID_PART) begin
        flash_rd = `FS_PART_CODE;
      end else if (faddr == `FS_SEC_ADDR) begin
        flash_rd = security_byte;
      end
    end
  end

  always_comb begin
    status_word = 32'h00000000;
    status_word[`FS_ST_BUSY] = busy;
    status_word[`FS_ST_IDMODE] = id_mode;
    status_word[`FS_ST_PROT] = protect;
    status_word[`FS_ST_LDRLOCK] = protect & (run_mode == `FS_MODE_SERIAL);
    status_word[`FS_ST_CMDEN] = cmd_en;
    status_word[`FS_ST_AREA_MSB:`FS_ST_AREA_LSB] = area_sel;
  end

  // ==========================================
  // control registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_field   <= `FS_EN_RESET;
      area_field <= `FS_AREA_RESET;
      cmd_en     <= 1'b0;
      area_sel   <= `FS_AREA_RESET;
      run_mode   <= `FS_MODE_NORMAL;
    end else if (rwr && !unmapped) begin
      case (wb_adr_i[3:2])
        `FS_REG_FIRST: begin
          en_field   <= wb_dat_i[`FS_EN_MSB:`FS_EN_LSB];
          area_field <= wb_dat_i[`FS_AREA_MSB:`FS_AREA_LSB];
        end
        `FS_REG_COMMIT: begin
          // enable and area settings act only after the key, guarding against stray writes
          if (wdat == `FS_COMMIT_KEY) begin
            cmd_en   <= en_field == `FS_EN_ON;
            area_sel <= area_field;
          end
        end
        `FS_REG_RUNMODE: run_mode <= wb_dat_i[1:0];
        default: run_mode <= run_mode;
      endcase
    end
  end

  // ==========================================
  // wishbone answer: one wait state, unmapped register reads give zero
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= take;
      if (take && !wb_we_i) begin
        if (!reg_space) begin
          wb_dat_o <= {24'h000000, flash_rd};
        end else if (unmapped) begin
          wb_dat_o <= 32'h00000000;
        end else begin
          case (wb_adr_i[3:2])
            `FS_REG_FIRST: begin
              wb_dat_o <= 32'h00000000;
              wb_dat_o[`FS_EN_MSB:`FS_EN_LSB] <= en_field;
              wb_dat_o[`FS_AREA_MSB:`FS_AREA_LSB] <= area_field;
            end
            `FS_REG_STATUS:  wb_dat_o <= status_word;
            `FS_REG_RUNMODE: wb_dat_o <= {30'h00000000, run_mode};
            default:         wb_dat_o <= 32'h00000000;
          endcase
        end
      end
    end
  end

  // ==========================================
  // checks
  sequence seq_prog_last;
    op_state == OP_PROG && prog_end;
  endsequence
  sequence seq_back_idle;
    op_state == OP_IDLE;
  endsequence
  // own cycle count: the window is far too long for a delay range
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) prog_age <= 13'h0000;
    else prog_age <= (busy && op_state != OP_ERASE) ? prog_age + 13'h0001 : 13'h0000;
  end

  AST_PROG_BOUND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (op_state == OP_PROG) |-> prog_age < 13'(PROG_MAX))
    else $error("byte program overran its time");
  AST_SEC_BOUND: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (op_state == OP_SEC) |-> prog_age < 13'(PROG_MAX))
    else $error("security program overran its time");
  AST_PROG_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    seq_prog_last |=> seq_back_idle ##0 (mem[$past(prog_addr)] == $past(prog_data)))
    else $error("programmed byte not stored");
  AST_FIRST_TOGGLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (start_prog || start_chip || start_sec) |=> toggle_bit)
    else $error("first toggle read not high");
  AST_TOGGLE_FLIP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (frd && busy && cmd_en && !start_prog) |=> toggle_bit != $past(toggle_bit))
    else $error("toggle bit did not invert");
  AST_BUSY_NO_CMD: assert property (@(posedge sys_clk) disable iff (!rst_n)
    busy |=> dec_state == DEC_IDLE && !$rose(id_mode))
    else $error("command accepted while busy");
  AST_DISABLED_REJECT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fwr && !cmd_en && busy) |=> $past(op_state) == op_state || op_state == OP_IDLE)
    else $error("disabled write disturbed running operation");
  AST_ERASE_FF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (op_state == OP_ERASE && !sweep_done) |=> mem[$past(sweep_idx)] == `FS_ERASED)
    else $error("erased byte not FF");
  AST_PROT_CLEAR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(security_byte == `FS_ERASED) |-> $past(op_state == OP_ERASE && erase_chip))
    else $error("protection cleared without chip erase");
  AST_PARALLEL_NO_SECTOR: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (run_mode == `FS_MODE_PARALL) |-> !start_sector)
    else $error("sector erase started in parallel mode");
  AST_ID_EXIT: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmd_ok && dec_state == DEC_IDLE && wdat == `FS_CMD_ID_OUT) |=> !id_mode)
    else $error("ID exit ignored");
  AST_MISMATCH_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cmd_ok && dec_state == DEC_UNLOCK1 && wdat != `FS_UNLOCK_2) |=> dec_state == DEC_IDLE)
    else $error("broken sequence not dropped");

endmodule
`default_nettype wire

// File: flash_seq_defines.svh
// constants of the flash command sequencer: map, command codes, timing
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

// ==========================================
// bus map
`define FS_ADR_W        19
`define FS_REG_SPACE    18
`define FS_REG_FIRST    2'h0
`define FS_REG_COMMIT   2'h1
`define FS_REG_STATUS   2'h2
`define FS_REG_RUNMODE  2'h3

// ==========================================
// register fields and reset values
`define FS_EN_LSB       0
`define FS_EN_MSB       2
`define FS_AREA_LSB     4
`define FS_AREA_MSB     5
`define FS_EN_RESET     3'h2
`define FS_EN_ON        3'h5
`define FS_AREA_RESET   2'h0
`define FS_AREA_DATA    2'h0
`define FS_AREA_CODE    2'h2
`define FS_COMMIT_KEY   8'hD5
`define FS_ST_BUSY      0
`define FS_ST_IDMODE    1
`define FS_ST_PROT      2
`define FS_ST_LDRLOCK   3
`define FS_ST_CMDEN     4
`define FS_ST_AREA_LSB  5
`define FS_ST_AREA_MSB  6
`define FS_MODE_NORMAL  2'h0
`define FS_MODE_SERIAL  2'h1
`define FS_MODE_PARALL  2'h2

// ==========================================
// command cycles
`define FS_ADDR_A       12'h555
`define FS_ADDR_B       12'hAAA
`define FS_UNLOCK_1     8'hAA
`define FS_UNLOCK_2     8'h55
`define FS_CMD_PROG     8'hA0
`define FS_CMD_ERASE    8'h80
`define FS_CMD_CHIP     8'h10
`define FS_CMD_SECTOR   8'h30
`define FS_CMD_ID_IN    8'h90
`define FS_CMD_ID_OUT   8'hF0
`define FS_CMD_SECURE   8'hA5
`define FS_SEC_ADDR     16'hFF7F
`define FS_SEC_DATA     8'h00
`define FS_ID_MAKER     16'hF000
`define FS_ID_PART      16'hF001
// arbitrary values standing in for the maker and part codes
`define FS_MAKER_CODE   8'h3C
`define FS_PART_CODE    8'h5A
`define FS_ERASED       8'hFF
`define FS_TOGGLE_BIT   6

// ==========================================
// timing
`define FS_CLK_MHZ      100
`define FS_PROG_US      40
`define FS_ERASE_MS     30
`define FS_PROG_CYCLES  (`FS_PROG_US * `FS_CLK_MHZ)
`define FS_ERASE_CYCLES (`FS_ERASE_MS * 1000 * `FS_CLK_MHZ)

`endif

// File: flash_seq_pkg.sv
// types of the flash command sequencer
package flash_seq_pkg;
  typedef enum logic [2:0] {
    DEC_IDLE, DEC_UNLOCK1, DEC_UNLOCK2, DEC_PROG, DEC_SECURE,
    DEC_ERASE1, DEC_ERASE2, DEC_ERASE3
  } dec_state_type;
  typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_SEC, OP_ERASE} op_state_type;
endpackage

// File: cpu_bus_model.sv
// cpu core model: classic wishbone master issuing single cycles
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input  wire logic        sys_clk,
  input  wire logic        ack,
  input  wire logic [31:0] rdat,
  output var  logic        cyc,
  output var  logic        stb,
  output var  logic        we,
  output var  logic [18:0] adr,
  output var  logic [3:0]  sel,
  output var  logic [31:0] wdat
);
  initial begin
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    adr  = 19'h00000;
    sel  = 4'h0;
    wdat = 32'h00000000;
  end
  // ==========================================
  // one transfer; caller sequences commands, bus idles one cycle between transfers
  task automatic xfer(input logic w, input logic [18:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge sys_clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'hF;
    wdat <= d;
    do @(posedge sys_clk); while (ack !== 1'b1);
    q = rdat;
    cyc  <= 1'b0;
    stb  <= 1'b0;
    we   <= 1'b0;
    // stale lines inverted so no old value looks valid
    adr  <= ~a;
    wdat <= ~d;
  endtask
endmodule
`default_nettype wire

// File: test_flash_command_sequencer.sv
// self-checking bench of the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module test_flash_command_sequencer;
  typedef struct packed {logic [18:0] a; logic [31:0] e;} row_type;
  logic        sys_clk;
  logic        rst_n;
  logic        cyc;
  logic        stb;
  logic        we;
  logic        ack;
  logic [18:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] q;
  int          errors;
  int          total_checks;
  int          cycles;
  row_type     rows [5] = '{'{19'h40000, 32'h2}, '{19'h40004, 32'h0},
    '{19'h40008, 32'h0}, '{19'h4000C, 32'h0}, '{19'h40010, 32'h0}};
  // small erase count keeps the run short; sweep length then dominates
  flash_command_sequencer #(.ERASE_CYCLES(100)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  cpu_bus_model u_cpu (
    .sys_clk(sys_clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb),
    .we(we), .adr(adr), .sel(sel), .wdat(wdat));
  // ==========================================
  // clock, timeout, report
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // ==========================================
  // bus helpers; flash byte f sits at word f, low lane
  task automatic fw(input logic [15:0] f, input logic [7:0] d);
    u_cpu.xfer(1'b1, {1'b0, f, 2'b00}, {24'h000000, d}, q);
  endtask
  task automatic fr(input logic [15:0] f);
    u_cpu.xfer(1'b0, {1'b0, f, 2'b00}, 32'h00000000, q);
  endtask
  task automatic rw(input logic [1:0] i, input logic [7:0] d);
    u_cpu.xfer(1'b1, {15'h4000, i, 2'b00}, {24'h000000, d}, q);
  endtask
  task automatic rr(input logic [1:0] i);
    u_cpu.xfer(1'b0, {15'h4000, i, 2'b00}, 32'h00000000, q);
  endtask
  task automatic setup(input logic [7:0] f);
    rw(2'h0, f);
    rw(2'h1, 8'hD5);
  endtask
  task automatic cmd(input logic [3:0] n, input logic [7:0] c);
    fw({n, 12'h555}, 8'hAA);
    fw({n, 12'hAAA}, 8'h55);
    fw({n, 12'h555}, c);
  endtask
  task automatic erase(input logic [15:0] a, input logic [7:0] c);
    cmd(4'hF, 8'h80);
    fw(16'hF555, 8'hAA);
    fw(16'hFAAA, 8'h55);
    fw(a, c);
  endtask
  // status polled, not flash, so the toggle sequence is left alone
  task automatic settle();
    for (int k = 0; k < 20000; k++) begin
      rr(2'h2);
      if (q[0] === 1'b0)
        break;
    end
    chk({31'h0, q[0]}, 32'h0);
  endtask
  // ==========================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    errors = 0;
    total_checks = 0;
    cycles = 0;
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      u_cpu.xfer(1'b0, rows[i].a, 32'h0, q);
      chk(q, rows[i].e);
    end
    cmd(4'hF, 8'hA0);
    fw(16'h8123, 8'h3C);
    rr(2'h2);
    chk(q, 32'h00);
    setup(8'h25);
    rr(2'h2);
    chk(q, 32'h50);
    cmd(4'h8, 8'hA0);
    fw(16'h8123, 8'h3C);
    fr(16'h0010);
    chk(q, 32'hFF);
    fr(16'h0010);
    chk(q, 32'hBF);
    cmd(4'hF, 8'h90);
    settle();
    rr(2'h2);
    chk(q, 32'h50);
    setup(8'h05);
    fr(16'h8123);
    chk(q, 32'h3C);
    fw(16'hF555, 8'hAA);
    fw(16'hFAAA, 8'h11);
    fw(16'hF555, 8'hA0);
    fw(16'h8200, 8'h77);
    rr(2'h2);
    chk(q, 32'h10);
    cmd(4'hF, 8'hA0);
    fw(16'h9004, 8'h00);
    setup(8'h02);
    fw(16'hF555, 8'hAA);
    fr(16'h0010);
    fr(16'h0010);
    chk(q, 32'hFF);
    settle();
    setup(8'h05);
    rw(2'h3, 8'h02);
    erase(16'h9FFF, 8'h30);
    rr(2'h2);
    chk(q, 32'h10);
    rw(2'h3, 8'h00);
    fr(16'h9004);
    chk(q, 32'h00);
    erase(16'h9ABC, 8'h30);
    settle();
    fr(16'h9004);
    chk(q, 32'hFF);
    fr(16'h8123);
    chk(q, 32'h3C);
    cmd(4'hF, 8'hA5);
    fw(16'hFF7F, 8'h00);
    fr(16'h0010);
    chk(q, 32'hFF);
    settle();
    rr(2'h2);
    chk(q, 32'h14);
    cmd(4'hF, 8'h90);
    fr(16'hF000);
    chk(q, 32'h3C);
    fr(16'hF001);
    chk(q, 32'h5A);
    fr(16'hFF7F);
    chk(q, 32'h00);
    fw(16'h1234, 8'hF0);
    rr(2'h2);
    chk(q, 32'h14);
    rw(2'h3, 8'h02);
    fr(16'h8123);
    chk(q, 32'h00);
    rw(2'h3, 8'h01);
    rr(2'h2);
    chk(q, 32'h1C);
    rw(2'h3, 8'h00);
    erase(16'hA000, 8'h30);
    settle();
    rr(2'h2);
    chk(q, 32'h14);
    erase(16'hF555, 8'h10);
    fr(16'h0010);
    chk(q, 32'hFF);
    fr(16'h0010);
    chk(q, 32'hBF);
    settle();
    rr(2'h2);
    chk(q, 32'h10);
    fr(16'h8123);
    chk(q, 32'hFF);
    cmd(4'hF, 8'h90);
    fr(16'hFF7F);
    chk(q, 32'hFF);
    // mid-run reset with id mode and commands on: both must come back off
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rr(2'h2);
    chk(q, 32'h00);
    rr(2'h0);
    chk(q, 32'h02);
    wrap_up();
  end
endmodule
`default_nettype wire
